/* rtl/dlc_pkg.sv */
// Package with register map, field positions and timing counts
package dlc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RING_HOLD_MS = 5000;
  localparam int unsigned WDOG_WINDOW_MS = 4096;
  localparam longint unsigned RING_HOLD_CYC =
    longint'(CLK_HZ) * RING_HOLD_MS / 1000;
  localparam longint unsigned WDOG_CYC =
    longint'(CLK_HZ) * WDOG_WINDOW_MS / 1000;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_HOOK = 8'h05;
  localparam logic [7:0] IDX_PWR = 8'h06;
  localparam logic [7:0] IDX_RATE = 8'h07;
  localparam logic [7:0] IDX_RSV8 = 8'h08;
  localparam logic [7:0] IDX_RSV9 = 8'h09;
  localparam logic [7:0] IDX_LOOP = 8'h0a;
  localparam logic [7:0] IDX_IDENT = 8'h0b;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_WDOG = 8'h22;
  localparam logic [7:0] IDX_SRST = 8'h23;
  // Field positions
  localparam int BIT_OFFHOOK = 0;
  localparam int BIT_RING_IND = 2;
  localparam int BIT_MONITOR = 3;
  localparam int BIT_RING_POS = 5;
  localparam int BIT_RING_NEG = 6;
  localparam int BIT_LINE_PD = 4;
  localparam int BIT_LOGIC_PD = 3;
  localparam int BIT_LOOPBACK = 0;
  localparam int BIT_RING_IRQ = 7;
  localparam int BIT_WDOG_IRQ = 0;
  localparam int BIT_WDOG_EN = 0;
  localparam int BIT_SRST = 0;
  // Reset values, rate code limit and response codes
  localparam logic [3:0] RATE_RESET = 4'h1;
  localparam logic [3:0] RATE_MAX = 4'h9;
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* rtl/dlc_if.sv */
// Interface carrying the decoded register access strobes
`timescale 1ns/1ps
interface dlc_reg_if;
  logic wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  logic wr_hit;
  modport slave (output wr_stb, wr_idx, wr_data, rd_idx,
                 input rd_data, rd_hit, wr_hit);
  modport core (input wr_stb, wr_idx, wr_data, rd_idx,
                output rd_data, rd_hit, wr_hit);
endinterface

/* rtl/dlc_axi_slave.sv */
// AXI4-Lite slave that turns bus cycles into register strobes
`timescale 1ns/1ps
module dlc_axi_slave
  import dlc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side
  dlc_reg_if.slave rif
);
  logic aw_ff, w_ff;
  logic [9:0] awi_ff;
  logic [7:0] wd_ff;
  logic wen_ff;

  assign s_awready = clk_en && !aw_ff && !s_bvalid;
  assign s_wready = clk_en && !w_ff && !s_bvalid;
  assign s_arready = clk_en && !s_rvalid;

  // Write strobe fires once both halves are held
  assign rif.wr_stb = clk_en && aw_ff && w_ff && !s_bvalid;
  // Addresses above the register window map to a free index that no register decodes
  localparam logic [7:0] IDX_UNUSED = 8'hff;
  assign rif.wr_idx = (awi_ff[9:8] == 2'b00) ? awi_ff[7:0] : IDX_UNUSED;
  assign rif.wr_data = wd_ff;
  assign rif.rd_idx = (s_araddr[11:10] == 2'b00) ?
                      s_araddr[9:2] : IDX_UNUSED;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awi_ff <= 10'h000;
      wd_ff <= 8'h00;
      wen_ff <= 1'b0;
    end else if (clk_en) begin
      if (s_awvalid && s_awready) begin
        aw_ff <= 1'b1;
        awi_ff <= s_awaddr[11:2];
      end
      if (s_wvalid && s_wready) begin
        w_ff <= 1'b1;
        wd_ff <= s_wdata[7:0];
        wen_ff <= s_wstrb[0];
      end
      if (rif.wr_stb) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (rif.wr_stb) begin
        s_bvalid <= 1'b1;
        s_bresp <= (rif.wr_hit && awi_ff[9:8] == 2'b00 && wen_ff) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= {24'h000000, rif.rd_data};
        s_rresp <= (rif.rd_hit && s_araddr[11:10] == 2'b00) ?
                   RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* rtl/dlc_line_ctrl.sv */
// Line control register bank: hook, ring, power-down, rate, loopback
// Contract
// [RL1] Bit 0 of the hook register drives the line off-hook when one.
// [RL2] Ring indicator sets on a ring, clears 5 s after the last positive ring or on off-hook.
// [RL3] Positive ring flag reads one while a positive ring is present.
// [RL4] Negative ring flag reads one while a negative ring is present.
// [RL5] Monitor bit selects low-power on-hook monitoring for caller ID.
// [RL6] Line-side power-down bit powers the line-side chip down while set.
// [RL7] Software programs the clock generator before clearing line-side power-down.
// [RL8] Logic power-down stays in force until a soft reset.
// [RL9] A four-bit code selects the sample rate, resetting to 0001, 1010-1111 reserved.
// [RL10] Digital loopback routes transmit data to receive so output equals input.
// [RL11] Software writes zero to reserved bits and ignores their read value.
// [RL12] Identity register is read-only: line-side code high, revision low.
// [RL13] An enabled watchdog forces on-hook when no write occurs in 4.096 s.
// [RL14] A detected ring sets a sticky ring interrupt flag that software clears. The code sets it only on a positive ring edge.
// [RL15] Registers are eight bits at their number; writes to status fields are ignored.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dlc_line_ctrl
  import dlc_pkg::*;
#(
  parameter longint unsigned RING_HOLD = RING_HOLD_CYC,
  parameter longint unsigned WDOG_LIMIT = WDOG_CYC,
  // Identity values are arbitrary
  parameter logic [3:0] LINE_ID = 4'h3,
  parameter logic [3:0] SYS_REV = 4'h1
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite register bus
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Ring detector inputs
  input wire logic ring_positive,
  input wire logic ring_negative,
  // Line-side controls
  output logic off_hook,
  output logic onhook_monitor_enable,
  output logic line_side_power_down,
  output logic logic_power_down,
  output logic [3:0] sample_rate_code,
  output logic digital_loopback_enable,
  // Sample datapath
  input wire logic [15:0] tx_sample,
  input wire logic [15:0] rx_from_line,
  output logic [15:0] rx_sample,
  // Interrupt
  output logic irq
);
  localparam int RCW = $clog2(RING_HOLD + 1);
  localparam int WCW = $clog2(WDOG_LIMIT + 1);

  dlc_reg_if rif ();

  dlc_axi_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rif(rif)
  );

  logic hook_ff;
  logic monitor_ff;
  logic line_pd_ff;
  logic logic_pd_ff;
  logic loop_ff;
  logic [3:0] rate_ff;
  logic ring_ind_ff;
  logic ring_pos_ff;
  logic ring_neg_ff;
  logic ring_pos_d_ff;
  logic [RCW-1:0] ring_cnt_ff;
  logic [WCW-1:0] wdog_cnt_ff;
  logic wdog_en_ff;
  logic [7:0] stat_ff;
  logic [7:0] mask_ff;
  logic [15:0] rx_ff;
  logic wr_ok;
  logic soft_rst;
  logic ring_rise;
  logic wdog_fire;
  logic [7:0] d;
  logic [7:0] rd_mux;
  logic rd_hit;

  assign d = rif.wr_data;
  // Logic power-down blocks writes except to the soft-reset and watchdog registers
  assign wr_ok = rif.wr_stb && !logic_pd_ff; // [RL8]
  assign soft_rst = rif.wr_stb && rif.wr_idx == IDX_SRST && d[BIT_SRST];
  assign ring_rise = ring_pos_ff && !ring_pos_d_ff;
  assign wdog_fire = wdog_en_ff && wdog_cnt_ff >= WCW'(WDOG_LIMIT - 1);

  // Hook and monitor bits; watchdog expiry drops the hook
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      hook_ff <= 1'b0;
      monitor_ff <= 1'b0;
    end else if (clk_en) begin
      if (wdog_fire) begin
        // Expiry beats a same-cycle hook write so the line really drops
        hook_ff <= 1'b0; // [RL13]
      end else if (wr_ok && rif.wr_idx == IDX_HOOK) begin
        hook_ff <= d[BIT_OFFHOOK]; // [RL1]
      end
      if (wr_ok && rif.wr_idx == IDX_HOOK) begin
        monitor_ff <= d[BIT_MONITOR]; // [RL5]
      end
    end
  end

  // Power-down bits; logic power-down leaves only via soft reset or hardware reset
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      line_pd_ff <= PWR_RESET[BIT_LINE_PD];
      logic_pd_ff <= PWR_RESET[BIT_LOGIC_PD];
    end else if (clk_en && wr_ok && rif.wr_idx == IDX_PWR) begin
      // Wake-up relies on software having set the clock generator first
      line_pd_ff <= d[BIT_LINE_PD]; // [RL6]
      logic_pd_ff <= d[BIT_LOGIC_PD]; // [RL8]
    end
  end

  // Reserved rate codes are refused and the old code kept
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      rate_ff <= RATE_RESET;
      loop_ff <= 1'b0;
    end else if (clk_en && wr_ok) begin
      if (rif.wr_idx == IDX_RATE && d[3:0] <= RATE_MAX) begin
        rate_ff <= d[3:0]; // [RL9]
      end
      if (rif.wr_idx == IDX_LOOP) begin
        loop_ff <= d[BIT_LOOPBACK]; // [RL10]
      end
    end
  end

  // Ring flags follow the detector; the indicator holds for 5 s
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_pos_ff <= 1'b0;
      ring_neg_ff <= 1'b0;
      ring_pos_d_ff <= 1'b0;
    end else if (clk_en) begin
      ring_pos_ff <= ring_positive; // [RL3]
      ring_neg_ff <= ring_negative; // [RL4]
      // Delayed copy finds the positive ring edge for the interrupt
      ring_pos_d_ff <= ring_pos_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      ring_ind_ff <= 1'b0;
      ring_cnt_ff <= '0;
    end else if (clk_en) begin
      if (hook_ff) begin
        ring_ind_ff <= 1'b0; // [RL2]
        ring_cnt_ff <= '0;
      end else if (ring_pos_ff) begin
        // Only a positive ring restarts the hold time
        ring_ind_ff <= 1'b1; // [RL2]
        ring_cnt_ff <= '0;
      end else if (ring_neg_ff && !ring_ind_ff) begin
        ring_ind_ff <= 1'b1; // [RL2]
        ring_cnt_ff <= '0;
      end else if (ring_ind_ff) begin
        if (ring_cnt_ff >= RCW'(RING_HOLD - 1)) begin
          ring_ind_ff <= 1'b0; // [RL2]
          ring_cnt_ff <= '0;
        end else begin
          ring_cnt_ff <= ring_cnt_ff + 1'b1;
        end
      end
    end
  end

  // Watchdog; once enabled only a hardware reset disables it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_en_ff <= 1'b0;
      wdog_cnt_ff <= '0;
    end else if (clk_en) begin
      if (rif.wr_stb && rif.wr_idx == IDX_WDOG && d[BIT_WDOG_EN]) begin
        wdog_en_ff <= 1'b1;
      end
      // Any write restarts the window, even one that is refused
      if (rif.wr_stb || !wdog_en_ff || wdog_fire) begin
        wdog_cnt_ff <= '0; // [RL13]
      end else begin
        wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
      end
    end
  end

  // Sticky interrupt status; an event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      stat_ff <= 8'h00;
      mask_ff <= 8'h00;
    end else if (clk_en) begin
      if (wr_ok && rif.wr_idx == IDX_IRQ_STAT) begin
        stat_ff <= stat_ff & ~d; // [RL14]
      end
      if (wr_ok && rif.wr_idx == IDX_IRQ_MASK) begin
        mask_ff <= d;
      end
      if (ring_rise) begin
        stat_ff[BIT_RING_IRQ] <= 1'b1; // [RL14]
      end
      if (wdog_fire) begin
        stat_ff[BIT_WDOG_IRQ] <= 1'b1;
      end
    end
  end

  // Loopback replaces line samples with the transmit stream
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_ff <= 16'h0000;
    end else if (clk_en) begin
      rx_ff <= loop_ff ? tx_sample : rx_from_line; // [RL10]
    end
  end

  // Read mux; reserved bits read zero, status writes are ignored
  always_comb begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    unique case (rif.rd_idx)
      IDX_HOOK: begin
        rd_mux[BIT_OFFHOOK] = hook_ff;
        rd_mux[BIT_RING_IND] = ring_ind_ff;
        rd_mux[BIT_MONITOR] = monitor_ff;
        rd_mux[BIT_RING_POS] = ring_pos_ff;
        rd_mux[BIT_RING_NEG] = ring_neg_ff;
      end
      IDX_PWR: begin
        rd_mux[BIT_LINE_PD] = line_pd_ff;
        rd_mux[BIT_LOGIC_PD] = logic_pd_ff;
      end
      IDX_RATE: rd_mux[3:0] = rate_ff;
      IDX_RSV8, IDX_RSV9: rd_mux = 8'h00;
      IDX_LOOP: rd_mux[BIT_LOOPBACK] = loop_ff;
      // Fixed bits; a write to this index changes nothing
      IDX_IDENT: rd_mux = {LINE_ID, SYS_REV}; // [RL12]
      IDX_IRQ_STAT: rd_mux = stat_ff;
      IDX_IRQ_MASK: rd_mux = mask_ff;
      IDX_WDOG: rd_mux[BIT_WDOG_EN] = wdog_en_ff;
      IDX_SRST: rd_mux = 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  assign rif.rd_data = rd_mux; // [RL15]
  assign rif.rd_hit = rd_hit;
  // Writes outside the map answer with an error response
  assign rif.wr_hit = (rif.wr_idx >= IDX_HOOK && rif.wr_idx <= IDX_IDENT) ||
                      (rif.wr_idx >= IDX_IRQ_STAT && rif.wr_idx <= IDX_SRST);

  assign off_hook = hook_ff; // [RL1]
  // Monitoring only makes sense on-hook, so it is gated off-hook
  assign onhook_monitor_enable = monitor_ff && !hook_ff; // [RL5]
  assign line_side_power_down = line_pd_ff; // [RL6]
  assign logic_power_down = logic_pd_ff;
  assign sample_rate_code = rate_ff;
  assign digital_loopback_enable = loop_ff;
  assign rx_sample = rx_ff;
  assign irq = |(stat_ff & mask_ff);
endmodule

/* verification/dlc_line_ctrl_props.sv */
// Checker for the line control register bank ports
`timescale 1ns/1ps
module dlc_line_ctrl_props
  import dlc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  // Line side
  input wire logic off_hook,
  input wire logic onhook_monitor_enable,
  input wire logic logic_power_down,
  input wire logic [3:0] sample_rate_code,
  input wire logic digital_loopback_enable,
  input wire logic [15:0] tx_sample,
  input wire logic [15:0] rx_sample
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  // Hook writes count only when the logic is powered
  sequence s_hook_wr;
    s_wr_take ##0 (s_awaddr == {2'b00, IDX_HOOK, 2'b00} && s_wstrb[0]
      && !logic_power_down);
  endsequence
  a_rate_reset_value: assert property ($rose(aresetn) |->
    sample_rate_code == RATE_RESET && !off_hook && !logic_power_down)
    else $error("reset values wrong");
  a_rate_code_legal: assert property (sample_rate_code <= RATE_MAX)
    else $error("reserved rate code applied");
  a_hook_follows_write: assert property (s_hook_wr |-> ##2
    off_hook == $past(s_wdata[0], 2))
    else $error("hook output does not follow write");
  a_logic_pd_sticky: assert property ($fell(logic_power_down) |->
    $past(s_awvalid && s_awready && s_wdata[BIT_SRST]
    && s_awaddr == {2'b00, IDX_SRST, 2'b00}, 2))
    else $error("logic power-down left without a soft reset");
  a_loop_data_path: assert property (clk_en && digital_loopback_enable
    |=> rx_sample == $past(tx_sample))
    else $error("loopback data differs");
  a_monitor_off_hook: assert property (off_hook |->
    !onhook_monitor_enable)
    else $error("monitor active while off-hook");
  a_write_resp_time: assert property (s_wr_take ##1 clk_en |=> s_bvalid)
    else $error("write response late");
  a_read_resp_time: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  a_read_upper_zero: assert property (s_rvalid |->
    s_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule
bind dlc_line_ctrl dlc_line_ctrl_props i_dlc_line_ctrl_props (.aclk,
  .aresetn, .clk_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
  .s_wstrb, .s_wvalid, .s_wready, .s_bvalid, .s_arvalid, .s_arready,
  .s_rdata, .s_rvalid, .off_hook, .onhook_monitor_enable,
  .logic_power_down, .sample_rate_code, .digital_loopback_enable,
  .tx_sample, .rx_sample);

/* verification/dlc_host_model.sv */
// Host model: AXI4-Lite master for the register bus
`timescale 1ns/1ps
module dlc_host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [11:0] s_awaddr,
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  output logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  output logic s_bready,
  // Read channels
  output logic [11:0] s_araddr,
  output logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  output logic s_rready,
  // High once an answer never came
  output logic hang
);
  initial {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready,
    s_araddr, s_arvalid, s_rready, hang} = '0;
  task automatic write(input logic [7:0] idx, input logic [7:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= {2'b00, idx, 2'b00};
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'hf;
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 64);
    r = s_bresp;
    s_bready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask
  task automatic read(input logic [7:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= {2'b00, idx, 2'b00};
    {s_arvalid, s_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 64);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    if (n >= 64) hang <= 1'b1;
  endtask
endmodule

/* verification/dlc_line_ctrl_tb.sv */
// Self-checking bench for the line control register bank
`timescale 1ns/1ps
module dlc_line_ctrl_tb import dlc_pkg::*; ();
  // Short counts keep the run brief
  localparam int RH = 50;
  localparam int WL = 80;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic ring_positive = 1'b0;
  logic ring_negative = 1'b0;
  logic [15:0] tx_sample = 16'h0;
  logic [15:0] rx_from_line = 16'h0;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rv;
  logic [3:0] s_wstrb, sample_rate_code;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, hang, irq, off_hook;
  logic onhook_monitor_enable, line_side_power_down, logic_power_down;
  logic digital_loopback_enable;
  logic [15:0] rx_sample;
  int fails = 0;
  int num_checks = 0;
  always #12.5 aclk = ~aclk;
  // Identity values are arbitrary
  dlc_line_ctrl #(.RING_HOLD(RH), .WDOG_LIMIT(WL), .LINE_ID(4'h3),
    .SYS_REV(4'h1)) i_dlc_line_ctrl (.aclk, .aresetn, .clk_en,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .ring_positive,
    .ring_negative, .off_hook, .onhook_monitor_enable,
    .line_side_power_down, .logic_power_down, .sample_rate_code,
    .digital_loopback_enable, .tx_sample, .rx_from_line, .rx_sample, .irq);
  dlc_host_model i_dlc_host_model (.aclk, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .hang);
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    i_dlc_host_model.write(i, d, rr);
  endtask
  task automatic rd(input logic [7:0] i);
    i_dlc_host_model.read(i, rv, rr);
  endtask
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge hang) begin
    fails++;
    print_verdict();
  end
  task automatic t_reset();
    rd(IDX_HOOK);
    chk("hook reset", rv, 32'h0);
    rd(IDX_IDENT);
    chk("identity", rv, 32'h31);
    wr(IDX_IDENT, 8'h00);
    rd(IDX_IDENT);
    chk("identity kept", rv, 32'h31);
    rd(8'h30);
    chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
  endtask
  task automatic t_hook();
    wr(IDX_HOOK, 8'h09);
    chk("off hook", 32'(off_hook), 32'h1);
    chk("monitor gated", 32'(onhook_monitor_enable), 32'h0);
    wr(IDX_HOOK, 8'h08);
    chk("on hook", 32'(off_hook), 32'h0);
    chk("monitor on", 32'(onhook_monitor_enable), 32'h1);
    wr(IDX_HOOK, 8'h64);
    rd(IDX_HOOK);
    chk("status bits", rv, 32'h0);
  endtask
  task automatic t_ring();
    wr(IDX_IRQ_MASK, 8'h80);
    ring_positive <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(IDX_HOOK);
    chk("ring positive", rv, 32'h24);
    chk("ring irq", 32'(irq), 32'h1);
    ring_positive <= 1'b0;
    ring_negative <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(IDX_HOOK);
    chk("ring negative", rv, 32'h44);
    ring_negative <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(IDX_HOOK);
    chk("ring held", rv, 32'h04);
    repeat (RH) @(posedge aclk);
    rd(IDX_HOOK);
    chk("ring expired", rv, 32'h0);
    chk("irq sticky", 32'(irq), 32'h1);
    wr(IDX_IRQ_STAT, 8'h80);
    chk("irq cleared", 32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 8'h00);
    ring_positive <= 1'b1;
    wr(IDX_HOOK, 8'h01);
    rd(IDX_HOOK);
    chk("ring off hook", rv, 32'h21);
    rd(IDX_IRQ_STAT);
    chk("masked status", rv, 32'h80);
    chk("masked irq", 32'(irq), 32'h0);
    ring_positive <= 1'b0;
    wr(IDX_IRQ_STAT, 8'h80);
    wr(IDX_HOOK, 8'h00);
  endtask
  task automatic t_power();
    wr(IDX_PWR, 8'h10);
    chk("line pd", 32'(line_side_power_down), 32'h1);
    wr(IDX_RATE, 8'h02); // Clock set up first
    wr(IDX_PWR, 8'h00);
    chk("line up", 32'(line_side_power_down), 32'h0);
    wr(IDX_PWR, 8'h08);
    chk("logic pd", 32'(logic_power_down), 32'h1);
    wr(IDX_RATE, 8'h05);
    chk("pd ignores", 32'(sample_rate_code), 32'h2);
    wr(IDX_PWR, 8'h00);
    chk("pd held", 32'(logic_power_down), 32'h1);
    wr(IDX_SRST, 8'h01);
    chk("soft reset", 32'(logic_power_down), 32'h0);
    chk("rate reset", 32'(sample_rate_code), 32'(RATE_RESET));
  endtask
  task automatic t_rate();
    logic [3:0] e;
    e = RATE_RESET;
    // Reserved codes must leave the previous rate in force
    for (int c = 0; c < 16; c++) begin
      wr(IDX_RATE, 8'(c));
      if (c <= 9) e = 4'(c);
      rd(IDX_RATE);
      chk("rate code", 32'(sample_rate_code), 32'(e));
      chk("rate read", rv, 32'(e));
    end
  endtask
  task automatic t_loop();
    tx_sample <= 16'h1234;
    rx_from_line <= 16'habcd;
    wr(IDX_LOOP, 8'h01);
    @(posedge aclk);
    chk("loop data", 32'(rx_sample), 32'h1234);
    wr(IDX_LOOP, 8'h00);
    @(posedge aclk);
    chk("line data", 32'(rx_sample), 32'habcd);
  endtask
  // Clock enable low must freeze the datapath and hold the readys low
  task automatic t_freeze();
    rx_from_line <= 16'h5a5a;
    clk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("frozen ready", 32'(s_awready), 32'h0);
    chk("frozen data", 32'(rx_sample), 32'habcd);
    clk_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("thawed data", 32'(rx_sample), 32'h5a5a);
  endtask
  // Last: a write restarts the watchdog window and expiry drops the hook
  task automatic t_wdog();
    wr(IDX_WDOG, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_HOOK, 8'h01);
    repeat (WL - 20) @(posedge aclk);
    wr(IDX_PWR, 8'h00);
    repeat (WL - 20) @(posedge aclk);
    chk("wdog restart", 32'(off_hook), 32'h1);
    repeat (30) @(posedge aclk);
    chk("wdog trip", 32'(off_hook), 32'h0);
    chk("wdog irq", 32'(irq), 32'h1);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_hook();
    t_ring();
    t_power();
    t_rate();
    t_loop();
    t_freeze();
    t_wdog();
    print_verdict();
  end
endmodule
